// ===== src/spp_pkg.sv
// Purpose: shared types and constants of the scanner pixel pipeline
// Assumes: 8 master clocks per pixel period
// Notes: enum order of spp_div_t follows the divide-factor code 0..7
package spp_pkg;
  localparam int PIX_W = 10;
  localparam int WIDE_W = 12;
  localparam int SUM_W = 14;
  localparam int BYTE_W = 8;
  localparam int TAB_DEPTH = 1024;
  localparam int NUM_TAB = 3;
  localparam int SLOTS = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int NIB = 4;
  localparam int LSB_PAD = 2;

  typedef enum logic [1:0] {MODE8, MODE10, MODE12} spp_mode_t;
  typedef enum logic [2:0] {DIV_1, DIV_1P5, DIV_2, DIV_3, DIV_4, DIV_6, DIV_8, DIV_12} spp_div_t;
  typedef enum logic [1:0] {DEP8, DEP4, DEP2, DEP1} spp_depth_t;
  typedef enum logic [2:0] {
    OP_IDLE, OP_OFS_RD, OP_GAIN_RD, OP_HI_WR, OP_LO_WR, OP_HI_RD, OP_LO_RD, OP_BUF_RD
  } spp_op_t;

  typedef struct packed {
    logic [PIX_W-1:0] pix;
    logic [1:0] lsb;
    logic [1:0] color;
    logic eol;
  } spp_pix_t;

  typedef struct packed {
    spp_mode_t mode;
    spp_div_t divf;
    spp_depth_t depth;
    logic half_duplex;
    logic chan_a_en;
    logic [1:0] chan_a_color;
  } spp_cfg_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [1:0] color;
    logic [PIX_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } spp_gp_t;

  localparam spp_op_t FULL_SCHED [SLOTS] = '{
    OP_OFS_RD, OP_GAIN_RD, OP_HI_WR, OP_HI_WR, OP_LO_WR, OP_LO_WR, OP_HI_RD, OP_LO_RD
  };
  localparam spp_op_t HALF_SCHED [4] = '{OP_OFS_RD, OP_GAIN_RD, OP_HI_WR, OP_LO_WR};
endpackage : spp_pkg

// ===== src/spp_top.sv
// Purpose: resolution reduction, gamma, packing, output formatting, sram slot plan
// Assumes: one input pixel per request, upstream gain stage already clamped
// Notes: the pipeline takes one pixel at a time and waits for it to drain
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// byte fifo
// ----------------------------------------
module spp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // pointers wrap naturally, so depth must be a power of two
  always_comb begin
    in_ready = cnt_q != (AW+1)'(D);
    out_valid = cnt_q != '0;
    out_data = mem[rp_q];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = wp_q + AW'(push);
    rp_d = rp_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : spp_fifo

// ----------------------------------------
// pixel processing top
// ----------------------------------------
// How it works
// - 8 and 10 bit modes average adjacent pixels; only 8 bit then applies gamma.
// - 8/10 bit outputs per line are input count div factor; short tail group dropped.
// - divide factors 1, 1.5, 2, 3, 4, 6, 8 and 12.
// - 10 bit: byte one low nibble bits 9..6, byte two bits 5..0 on top.
// - duplex select bit picks full or half duplex sram plan in 10/12 bit.
// - full duplex: six accesses in eight clocks, writes two, reads two for host.
// - half duplex fill: four two-clock accesses, no host reads until full.
// - half duplex drain: two clocks per byte read for host.
// - 12 bit pixel is 10 bit product with two converter lsbs appended.
// - 12 bit: byte one low nibble bits 11..8, byte two bits 7..0.
// - 12 bit mode uses the same duplex choices as 10 bit.
// - three 1K by 8 gamma tables map 10 bit to 8 bit.
// - gamma tables written and read via data port with colour select.
// - single channel mode A exposes only the chosen colour's table.
// - depth 4/2/1 packs top bits, earliest pixel in msbs.
// - incomplete packed byte at line end is not sent.
// - 8 bit path: average, gamma, pack, then buffer.
// - input is the 10 bit clamped product, never above 1023.
module spp_top
  import spp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready_q,
  input wire spp_pix_t in_px,
  input wire spp_cfg_t cfg,
  input wire spp_gp_t gp,
  output logic [BYTE_W-1:0] gp_rdata_q,
  output logic gp_rvalid_q,
  input wire logic buf_full,
  input wire logic buf_empty,
  output spp_op_t sram_op_q,
  output logic host_byte_q,
  output logic out_valid_q,
  output logic [BYTE_W-1:0] out_data_q,
  input wire logic out_ready
);
  function automatic logic [3:0] grp_size(spp_div_t d, logic alt);
    unique case (d)
      DIV_1: grp_size = 4'h1;
      DIV_1P5: grp_size = alt ? 4'h1 : 4'h2;
      DIV_2: grp_size = 4'h2;
      DIV_3: grp_size = 4'h3;
      DIV_4: grp_size = 4'h4;
      DIV_6: grp_size = 4'h6;
      DIV_8: grp_size = 4'h8;
      DIV_12: grp_size = 4'hc;
    endcase
  endfunction : grp_size

  function automatic logic [PIX_W-1:0] avg_of(logic [SUM_W-1:0] s, logic [3:0] n);
    avg_of = PIX_W'(s / SUM_W'(n));
  endfunction : avg_of

  function automatic logic [1:0] tab_of(logic [1:0] c);
    tab_of = (c == 2'(NUM_TAB)) ? 2'h0 : c;
  endfunction : tab_of

  // ----------------------------------------
  // averaging stage
  // ----------------------------------------
  logic take, in_ready_d, alt_q, alt_d, avg_v_q, avg_v_d, keep_q, keep_d, eol_q, eol_d;
  logic [3:0] gcnt_q, gcnt_d, gsize;
  logic [SUM_W-1:0] sum_q, sum_d, sum_n;
  logic [WIDE_W-1:0] avg_q, avg_d;
  logic [1:0] col_q, col_d;
  logic gam_v_q, gam_v_d, gkeep_q, gkeep_d, geol_q, geol_d;
  logic [BYTE_W-1:0] gam_q, pk_q, pk_d, pk_n, eb0_q, eb0_d, eb1_q, eb1_d;
  logic [2:0] pcnt_q, pcnt_d, plast;
  logic [1:0] npend_q, npend_d;
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [BYTE_W-1:0] f_out_data;
  logic [BYTE_W-1:0] gmem [NUM_TAB][TAB_DEPTH];

  always_comb begin
    take = in_valid && in_ready_q;
    gsize = grp_size(cfg.divf, alt_q);
    sum_n = sum_q + SUM_W'(in_px.pix);
    gcnt_d = gcnt_q;
    sum_d = sum_q;
    alt_d = alt_q;
    avg_v_d = 1'b0;
    keep_d = 1'b0;
    avg_d = avg_q;
    col_d = col_q;
    eol_d = 1'b0;
    if (take) begin
      col_d = cfg.chan_a_en ? cfg.chan_a_color : in_px.color;
      eol_d = in_px.eol;
      avg_v_d = 1'b1;
      if (cfg.mode == MODE12) begin
        keep_d = 1'b1;
        avg_d = {in_px.pix, in_px.lsb};
      end else if (gcnt_q == gsize - 4'h1) begin
        keep_d = 1'b1;
        avg_d = WIDE_W'(avg_of(sum_n, gsize));
        gcnt_d = '0;
        sum_d = '0;
        alt_d = (cfg.divf == DIV_1P5) && !alt_q;
      end else if (in_px.eol) begin
        gcnt_d = '0;
        sum_d = '0;
      end else begin
        gcnt_d = gcnt_q + 4'h1;
        sum_d = sum_n;
      end
      if (in_px.eol) begin
        alt_d = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // gamma, packing and byte emitter
  // ----------------------------------------
  always_comb begin
    gam_v_d = avg_v_q && (cfg.mode == MODE8);
    gkeep_d = keep_q;
    geol_d = eol_q;
    unique case (cfg.depth)
      DEP8: begin
        pk_n = gam_q;
        plast = 3'h0;
      end
      DEP4: begin
        pk_n = {pk_q[NIB-1:0], gam_q[BYTE_W-1 -: NIB]};
        plast = 3'h1;
      end
      DEP2: begin
        pk_n = {pk_q[BYTE_W-3:0], gam_q[BYTE_W-1 -: 2]};
        plast = 3'h3;
      end
      DEP1: begin
        pk_n = {pk_q[BYTE_W-2:0], gam_q[BYTE_W-1]};
        plast = 3'h7;
      end
    endcase
    pk_d = pk_q;
    pcnt_d = pcnt_q;
    eb0_d = eb0_q;
    eb1_d = eb1_q;
    npend_d = npend_q;
    if (npend_q != 2'h0 && f_in_ready) begin
      eb0_d = eb1_q;
      npend_d = npend_q - 2'h1;
    end
    if (avg_v_q && keep_q && cfg.mode != MODE8) begin
      npend_d = 2'h2;
      if (cfg.mode == MODE12) begin
        eb0_d = {{NIB{1'b0}}, avg_q[WIDE_W-1 -: NIB]};
        eb1_d = avg_q[BYTE_W-1:0];
      end else begin
        eb0_d = {{NIB{1'b0}}, avg_q[PIX_W-1 -: NIB]};
        eb1_d = {avg_q[PIX_W-NIB-1:0], {LSB_PAD{1'b0}}};
      end
    end
    if (gam_v_q && gkeep_q) begin
      pk_d = pk_n;
      pcnt_d = pcnt_q + 3'h1;
      if (pcnt_q == plast) begin
        pcnt_d = '0;
        eb0_d = pk_n;
        npend_d = 2'h1;
      end
    end
    if (gam_v_q && geol_q) begin
      pcnt_d = '0;
    end
    in_ready_d = !take && npend_d == 2'h0 && !avg_v_d && !gam_v_d;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      in_ready_q <= 1'b0;
      gcnt_q <= '0;
      sum_q <= '0;
      alt_q <= 1'b0;
      avg_v_q <= 1'b0;
      keep_q <= 1'b0;
      avg_q <= '0;
      col_q <= '0;
      eol_q <= 1'b0;
      gam_v_q <= 1'b0;
      gkeep_q <= 1'b0;
      geol_q <= 1'b0;
      pk_q <= '0;
      pcnt_q <= '0;
      eb0_q <= '0;
      eb1_q <= '0;
      npend_q <= '0;
    end else begin
      in_ready_q <= in_ready_d;
      gcnt_q <= gcnt_d;
      sum_q <= sum_d;
      alt_q <= alt_d;
      avg_v_q <= avg_v_d;
      keep_q <= keep_d;
      avg_q <= avg_d;
      col_q <= col_d;
      eol_q <= eol_d;
      gam_v_q <= gam_v_d;
      gkeep_q <= gkeep_d;
      geol_q <= geol_d;
      pk_q <= pk_d;
      pcnt_q <= pcnt_d;
      eb0_q <= eb0_d;
      eb1_q <= eb1_d;
      npend_q <= npend_d;
    end
  end

  // ----------------------------------------
  // gamma tables and data port
  // ----------------------------------------
  // colour code 3 is not a table; it falls back to red rather than read nothing
  logic [1:0] gp_tab;
  always_comb begin
    gp_tab = tab_of(cfg.chan_a_en ? cfg.chan_a_color : gp.color);
  end

  always_ff @(posedge clock) begin
    if (gp.we) begin
      gmem[gp_tab][gp.addr] <= gp.wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gam_q <= '0;
      gp_rdata_q <= '0;
      gp_rvalid_q <= 1'b0;
    end else begin
      gam_q <= gmem[tab_of(col_q)][avg_q[PIX_W-1:0]];
      gp_rdata_q <= gmem[gp_tab][gp.addr];
      gp_rvalid_q <= gp.re;
    end
  end

  // ----------------------------------------
  // output buffer and register
  // ----------------------------------------
  spp_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(npend_q != 2'h0),
    .in_ready(f_in_ready),
    .in_data(eb0_q),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  logic out_valid_d;
  logic [BYTE_W-1:0] out_data_d;
  always_comb begin
    f_out_ready = !out_valid_q || out_ready;
    out_valid_d = out_valid_q && !out_ready;
    out_data_d = out_data_q;
    if (f_out_valid && f_out_ready) begin
      out_valid_d = 1'b1;
      out_data_d = f_out_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  // ----------------------------------------
  // sram slot plan
  // ----------------------------------------
  logic [2:0] slot_q, slot_d;
  logic hd_rd_q, hd_rd_d, half, host_byte_d;
  spp_op_t op_d;
  always_comb begin
    half = cfg.half_duplex && cfg.mode != MODE8;
    slot_d = slot_q + 3'h1;
    hd_rd_d = half && (hd_rd_q ? !buf_empty : buf_full);
    if (!half) begin
      op_d = FULL_SCHED[slot_q];
      host_byte_d = op_d == OP_HI_RD || op_d == OP_LO_RD;
    end else if (!hd_rd_q) begin
      op_d = HALF_SCHED[slot_q[2:1]];
      host_byte_d = 1'b0;
    end else begin
      op_d = OP_BUF_RD;
      host_byte_d = slot_q[0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slot_q <= '0;
      hd_rd_q <= 1'b0;
      sram_op_q <= OP_IDLE;
      host_byte_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      hd_rd_q <= hd_rd_d;
      sram_op_q <= op_d;
      host_byte_q <= host_byte_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  grp_done_a: assert property (take && cfg.mode != MODE12 && gcnt_q == gsize - 4'h1 |=> avg_v_q && keep_q) else $error("group not averaged");
  tail_drop_a: assert property (take && cfg.mode != MODE12 && in_px.eol && gcnt_q != gsize - 4'h1 |=> avg_v_q && !keep_q ##1 (!gam_v_q || !gkeep_q)) else $error("tail group kept");
  wide_pix_a: assert property (take && cfg.mode == MODE12 |=> avg_q == {$past(in_px.pix), $past(in_px.lsb)}) else $error("12 bit rebuild");
  ten_hi_a: assert property (avg_v_q && keep_q && cfg.mode == MODE10 |=> npend_q == 2'h2 && eb0_q[NIB-1:0] == $past(avg_q[PIX_W-1:PIX_W-NIB]) && eb1_q[BYTE_W-1:LSB_PAD] == $past(avg_q[PIX_W-NIB-1:0])) else $error("10 bit byte format");
  // duplex may be switched at any slot, so the plan must stay full for both read slots
  full_read_a: assert property (!half && slot_q == 3'h6 ##1 !half |-> sram_op_q == OP_HI_RD ##1 sram_op_q == OP_LO_RD) else $error("full duplex reads");
  half_hold_a: assert property (half && !hd_rd_q |=> !host_byte_q) else $error("host read while filling");
  drain_rate_a: assert property (host_byte_q && sram_op_q == OP_BUF_RD |=> !host_byte_q) else $error("drain faster than two clocks");
  pack_clear_a: assert property (gam_v_q && geol_q |=> pcnt_q == 3'h0) else $error("partial byte carried");
  gamma_path_a: assert property (avg_v_q && cfg.mode == MODE8 |=> gam_v_q) else $error("gamma stage skipped");
  one_pix_a: assert property (take |=> !in_ready_q) else $error("pipeline overrun");

  mode8_c: cover property (gam_v_q && gkeep_q && npend_d == 2'h1);
  mode10_c: cover property (avg_v_q && keep_q && cfg.mode == MODE10);
  drain_c: cover property (!hd_rd_q ##1 hd_rd_q);
  fifo_full_c: cover property (!f_in_ready);
endmodule : spp_top

`default_nettype wire

// ===== verification/spp_sink.sv
// Purpose: far side of the pixel pipe: sram line buffer drained by the host
// Assumes: one buffered byte per accepted output beat
// Notes: tracks the byte level only, addresses are not modelled
`timescale 1ns/1ps
`default_nettype none
module spp_sink #(
  parameter int FULL_AT = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] pace,
  input wire logic out_valid_q,
  input wire logic host_byte_q,
  output logic out_ready,
  output logic buf_full,
  output logic buf_empty
);
  int level;
  logic tick_q;
  logic [1:0] pace_q;
  // pace 0 always ready, 1 every other cycle, 2 stalled
  // pace is registered so ready only moves on the rising edge
  assign out_ready = (pace_q == 2'h0) || (pace_q == 2'h1 && tick_q);
  assign buf_full = level >= FULL_AT;
  assign buf_empty = level == 0;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      level <= 0;
      tick_q <= 1'b0;
      pace_q <= 2'h0;
    end else begin
      tick_q <= !tick_q;
      pace_q <= pace;
      level <= level + int'(out_valid_q && out_ready) - int'(host_byte_q && level > 0);
    end
  end
endmodule : spp_sink
`default_nettype wire

// ===== verification/test_scanner_pixel_processing.sv
// Purpose: self-checking bench for the pixel pipe
// Assumes: red gamma entry a holds a[9:2]
// Notes: drain waits are fixed spans, long enough for any line here
`timescale 1ns/1ps
`default_nettype none
module test_scanner_pixel_processing import spp_pkg::*;;
  typedef struct {
    spp_mode_t mode;
    spp_div_t divf;
    spp_depth_t dep;
    logic [1:0] lsb;
    int n;
    logic [9:0] px [8];
    int ne;
    logic [7:0] e [2];
  } spp_row_t;
  logic clock;
  logic rstn = 1'b0;
  logic in_valid = 1'b0;
  spp_pix_t in_px = '0;
  spp_cfg_t cfg = '0;
  spp_gp_t gp = '0;
  logic [1:0] pace = 2'h0;
  logic [1:0] pcol = 2'h0;
  logic in_ready_q, gp_rvalid_q, buf_full, buf_empty, host_byte_q, out_valid_q, out_ready;
  logic [7:0] gp_rdata_q, out_data_q;
  logic [9:0] p;
  spp_op_t sram_op_q;
  logic [7:0] got [$];
  int n_fail = 0;
  int total_checks = 0;
  int k;
  spp_op_t full_s [8] = '{OP_OFS_RD, OP_GAIN_RD, OP_HI_WR, OP_HI_WR, OP_LO_WR, OP_LO_WR,
    OP_HI_RD, OP_LO_RD};
  spp_op_t half_s [8] = '{OP_OFS_RD, OP_OFS_RD, OP_GAIN_RD, OP_GAIN_RD, OP_HI_WR, OP_HI_WR,
    OP_LO_WR, OP_LO_WR};
  int fac [6] = '{2, 3, 4, 6, 8, 12};
  logic [7:0] half_e [4] = '{8'h0f, 8'hff, 8'h00, 8'h01};
  spp_row_t rows [8] = '{
    '{MODE10, DIV_1, DEP8, 2'h0, 1, '{0: 10'h3a5, default: 10'h000}, 2, '{8'h0e, 8'h94}},
    '{MODE12, DIV_1, DEP8, 2'h2, 1, '{0: 10'h3a5, default: 10'h000}, 2, '{8'h0e, 8'h96}},
    '{MODE10, DIV_2, DEP8, 2'h0, 3, '{0: 10'h064, 1: 10'h0c9, 2: 10'h12c, default: 10'h000},
      2, '{8'h02, 8'h58}},
    '{MODE8, DIV_3, DEP8, 2'h0, 4, '{0: 10'h01e, 1: 10'h03c, 2: 10'h05b, 3: 10'h005,
      default: 10'h000}, 1, '{8'h0f, 8'h00}},
    '{MODE8, DIV_1, DEP4, 2'h0, 3, '{0: 10'h3e8, 1: 10'h190, 2: 10'h1f4, default: 10'h000},
      1, '{8'hf6, 8'h00}},
    '{MODE8, DIV_1P5, DEP8, 2'h0, 3, '{0: 10'h064, 1: 10'h0c8, 2: 10'h12c,
      default: 10'h000}, 2, '{8'h25, 8'h4b}},
    '{MODE8, DIV_1, DEP2, 2'h0, 4, '{0: 10'h3ff, 1: 10'h000, 2: 10'h200, 3: 10'h100,
      default: 10'h000}, 1, '{8'hc9, 8'h00}},
    '{MODE8, DIV_1, DEP1, 2'h0, 8, '{10'h3ff, 10'h000, 10'h000, 10'h3ff, 10'h3ff, 10'h000,
      10'h3ff, 10'h000}, 1, '{8'h9a, 8'h00}}};
  spp_top uut (.clock(clock), .rstn(rstn), .in_valid(in_valid), .in_ready_q(in_ready_q),
    .in_px(in_px), .cfg(cfg), .gp(gp), .gp_rdata_q(gp_rdata_q), .gp_rvalid_q(gp_rvalid_q),
    .buf_full(buf_full), .buf_empty(buf_empty), .sram_op_q(sram_op_q),
    .host_byte_q(host_byte_q), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
    .out_ready(out_ready));
  spp_sink sink (.clock(clock), .rstn(rstn), .pace(pace), .out_valid_q(out_valid_q),
    .host_byte_q(host_byte_q), .out_ready(out_ready), .buf_full(buf_full),
    .buf_empty(buf_empty));
  // ----
  // helpers
  // ----
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(negedge clock) begin
    if (out_valid_q === 1'b1 && out_ready === 1'b1) got.push_back(out_data_q);
  end
  task automatic chk_b(string nm, logic [7:0] ex, logic [7:0] sn);
    total_checks++;
    if (sn !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk_b
  task automatic chk_op(spp_op_t ex, spp_op_t sn);
    total_checks++;
    if (sn !== ex) begin
      n_fail++;
      $display("wrong value sram_op expected %0d seen %0d", ex, sn);
    end
  endtask : chk_op
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // pixels stay below 1024, as the clamped gain product does
  task automatic send_px(logic [9:0] px, logic [1:0] l, logic eol);
    int w;
    w = 0;
    while (in_ready_q !== 1'b1 && w < 200) begin
      @(negedge clock);
      w++;
    end
    in_px = '{pix: px, lsb: l, color: pcol, eol: eol};
    in_valid = 1'b1;
    @(negedge clock);
    in_valid = 1'b0;
  endtask : send_px
  // strobes stay up between back-to-back calls; the caller releases the port
  task automatic gp_wr(logic [1:0] c, logic [9:0] a, logic [7:0] d);
    gp = '{we: 1'b1, re: 1'b0, color: c, addr: a, wdata: d};
    @(negedge clock);
  endtask : gp_wr
  task automatic gp_rd(logic [1:0] c, logic [9:0] a, logic [7:0] d);
    gp = '{we: 1'b0, re: 1'b1, color: c, addr: a, wdata: 8'h00};
    @(negedge clock);
    chk_b("gp_rdata", d, gp_rdata_q);
    chk_b("gp_rvalid", 8'h01, {7'h00, gp_rvalid_q});
  endtask : gp_rd
  task automatic drain(int ne);
    repeat (60) @(negedge clock);
    chk_b("byte_count", 8'(ne), 8'(got.size()));
  endtask : drain
  task automatic sched(spp_op_t s [8], logic [7:0] hb);
    k = 0;
    while (sram_op_q !== s[7] && k < 20) begin
      @(negedge clock);
      k++;
    end
    while (sram_op_q === s[7] && k < 40) begin
      @(negedge clock);
      k++;
    end
    for (int j = 0; j < 8; j++) begin
      chk_op(s[j], sram_op_q);
      chk_b("host_byte", {7'h00, hb[j]}, {7'h00, host_byte_q});
      @(negedge clock);
    end
  endtask : sched
  // ----
  // sequence
  // ----
  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clock);
    chk_op(OP_IDLE, sram_op_q);
    chk_b("idle_outs", 8'h00, {5'h00, out_valid_q, in_ready_q, host_byte_q});
    @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    sched(full_s, 8'hc0);
    for (int a = 0; a < 1024; a++) gp_wr(2'h0, 10'(a), 8'(a >> 2));
    gp_wr(2'h1, 10'h005, 8'h3c);
    gp_wr(2'h2, 10'h005, 8'hc3);
    gp_rd(2'h0, 10'h005, 8'h01);
    gp_rd(2'h1, 10'h005, 8'h3c);
    gp_rd(2'h2, 10'h005, 8'hc3);
    gp_rd(2'h0, 10'h3ff, 8'hff);
    cfg.chan_a_en = 1'b1;
    cfg.chan_a_color = 2'h2;
    gp_wr(2'h0, 10'h005, 8'h77);
    gp_rd(2'h1, 10'h005, 8'h77);
    cfg.chan_a_en = 1'b0;
    gp_rd(2'h2, 10'h005, 8'h77);
    gp_rd(2'h0, 10'h005, 8'h01);
    gp = '0;
    foreach (rows[i]) begin
      // 12 bit row keeps horizontal_divide_factor-one, 10 bit rows need no gamma
      cfg.mode = rows[i].mode;
      cfg.divf = rows[i].divf;
      cfg.depth = rows[i].dep;
      pace = 2'(i % 2);
      got.delete();
      for (int j = 0; j < rows[i].n; j++) send_px(rows[i].px[j], rows[i].lsb, j == rows[i].n - 1);
      drain(rows[i].ne);
      for (int j = 0; j < rows[i].ne; j++) chk_b("out_byte", rows[i].e[j], got[j]);
    end
    cfg.depth = DEP8;
    for (int d = 0; d < 6; d++) begin
      cfg.divf = spp_div_t'(d + 2);
      got.delete();
      for (int j = 0; j <= fac[d]; j++) send_px(10'h190, 2'h0, j == fac[d]);
      drain(1);
      chk_b("div_byte", 8'h64, got[0]);
    end
    // pixel colour picks the table; channel A overrides it
    cfg.divf = DIV_1;
    pcol = 2'h1;
    got.delete();
    send_px(10'h005, 2'h0, 1'b1);
    cfg.chan_a_en = 1'b1;
    send_px(10'h005, 2'h0, 1'b1);
    drain(2);
    chk_b("green_byte", 8'h3c, got[0]);
    chk_b("chan_a_byte", 8'h77, got[1]);
    cfg.chan_a_en = 1'b0;
    pcol = 2'h0;
    cfg.mode = MODE10;
    cfg.divf = DIV_1;
    pace = 2'h2;
    got.delete();
    for (int j = 0; j < 17; j++) send_px(10'(j * 61), 2'h0, 1'b0);
    k = 0;
    repeat (30) begin
      @(negedge clock);
      k += int'(in_ready_q === 1'b1);
    end
    chk_b("ready_when_full", 8'h00, 8'(k));
    pace = 2'h0;
    send_px(10'h3ff, 2'h0, 1'b1);
    drain(36);
    for (int j = 0; j < 18; j++) begin
      p = (j < 17) ? 10'(j * 61) : 10'h3ff;
      chk_b("fifo_hi", {4'h0, p[9:6]}, got[2 * j]);
      chk_b("fifo_lo", {p[5:0], 2'h0}, got[2 * j + 1]);
    end
    k = 0;
    while (buf_empty !== 1'b1 && k < 500) begin
      @(negedge clock);
      k++;
    end
    cfg.mode = MODE12;
    cfg.half_duplex = 1'b1;
    sched(half_s, 8'h00);
    got.delete();
    send_px(10'h3ff, 2'h3, 1'b0);
    send_px(10'h000, 2'h1, 1'b1);
    k = 0;
    while (sram_op_q !== OP_BUF_RD && k < 100) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    repeat (4) begin
      chk_op(OP_BUF_RD, sram_op_q);
      k += int'(host_byte_q === 1'b1);
      @(negedge clock);
    end
    chk_b("host_reads", 8'h02, 8'(k));
    drain(4);
    for (int j = 0; j < 4; j++) chk_b("half_byte", half_e[j], got[j]);
    give_verdict();
  end
endmodule : test_scanner_pixel_processing
`default_nettype wire
